// >>> shared/hpsh_regs.svh
// Notes on behaviour
// [RL1] Strobe active: select low, data strobes differ
// [RL2] Selects: access type, direction; halfword adds order
// [RL3] Host holds strobe until wait indicator low
// [RL4] Data read fetches word at first strobe
// [RL5] Data write waits while write buffer full; the code lets a low halfword write in halfword mode go on without waiting
// [RL6] Address latch pulsed at most once per strobe
// [RL7] Address latch optional; may stay high always
// [RL8] Bus driven only on reads, released after strobe
// [RL9] Selects latched at latch fall, else strobe fall
`ifndef HPSH_REGS_SVH
`define HPSH_REGS_SVH

// Access type codes
`define HPSH_ACC_CTRL        2'h0
`define HPSH_ACC_ADDR        2'h1
`define HPSH_ACC_DATA_INC    2'h2
`define HPSH_ACC_DATA_FIX    2'h3
`define HPSH_ADDR_STEP       32'h00000004
`define HPSH_RST_WORD        32'h00000000

// Strobe timing at a 10 ns clock
`define HPSH_CLK_PERIOD_NS   10
`define HPSH_STB_LOW_P       4
`define HPSH_STB_LOW_NS_X10  125
`define HPSH_STB_LOW_CYC_NS  ((`HPSH_STB_LOW_NS_X10 + `HPSH_CLK_PERIOD_NS * 10 - 1) / (`HPSH_CLK_PERIOD_NS * 10))
`define HPSH_STB_LOW_CYC     ((`HPSH_STB_LOW_P > `HPSH_STB_LOW_CYC_NS) ? `HPSH_STB_LOW_P : `HPSH_STB_LOW_CYC_NS)
`define HPSH_STB_HIGH_CYC    4

// Host controller register offsets
`define HPSH_OFS_CTRL        12'h000
`define HPSH_OFS_CMD         12'h004
`define HPSH_OFS_WDATA       12'h008
`define HPSH_OFS_RDATA       12'h00C
`define HPSH_OFS_STATUS      12'h010

// Host controller fields
`define HPSH_CTRL_HW_BIT     0
`define HPSH_CTRL_ALS_BIT    1
`define HPSH_CMD_TYPE_LSB    0
`define HPSH_CMD_RD_BIT      2
`define HPSH_CMD_ORDER_BIT   3
`define HPSH_STAT_BUSY_BIT   0
`define HPSH_STAT_DONE_BIT   1

`endif

// >>> shared/hpsh_pkg.sv
package hpsh_pkg;
  typedef logic [31:0] hpsh_word_t;
  typedef logic [1:0]  hpsh_acc_t;

  typedef enum logic [3:0] {
    DEV_IDLE  = 4'b0001,
    DEV_FETCH = 4'b0010,
    DEV_STALL = 4'b0100,
    DEV_HOLD  = 4'b1000
  } hpsh_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'b0001,
    HST_SETUP = 4'b0010,
    HST_LOW   = 4'b0100,
    HST_GAP   = 4'b1000
  } hpsh_host_state_t;
endpackage

// >>> shared/hpsh_if.sv
`timescale 1ns/1ps
interface hpsh_if;
  logic                 host_chip_select_n;
  logic                 host_data_strobe_one;
  logic                 host_data_strobe_two;
  hpsh_pkg::hpsh_acc_t  access_type_select;
  logic                 read_write_select;
  logic                 halfword_order_select;
  logic                 addr_latch_strobe_n;
  logic                 halfword_bus_mode;
  logic                 host_wait_indicator;
  hpsh_pkg::hpsh_word_t host_out;
  logic                 host_oe;
  hpsh_pkg::hpsh_word_t dev_out;
  logic                 dev_oe;
  hpsh_pkg::hpsh_word_t host_data_bus;

  // Resolved bus level; an undriven bus reads as zero
  assign host_data_bus = dev_oe ? dev_out : (host_oe ? host_out : 32'h00000000);

  modport dev (
    input  host_chip_select_n, host_data_strobe_one, host_data_strobe_two,
    input  access_type_select, read_write_select, halfword_order_select,
    input  addr_latch_strobe_n, halfword_bus_mode, host_data_bus,
    output host_wait_indicator, dev_out, dev_oe
  );

  modport host (
    output host_chip_select_n, host_data_strobe_one, host_data_strobe_two,
    output access_type_select, read_write_select, halfword_order_select,
    output addr_latch_strobe_n, halfword_bus_mode, host_out, host_oe,
    input  host_wait_indicator, host_data_bus
  );
endinterface

// >>> verilog/hpsh_device.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "hpsh_regs.svh"
module hpsh_device (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Link to the host
  hpsh_if.dev                       link,
  // Internal transfer engine
  output      logic                 xfer_fetch,
  output      logic                 xfer_push,
  output      hpsh_pkg::hpsh_word_t xfer_addr,
  output      hpsh_pkg::hpsh_word_t xfer_wdata,
  input  wire logic                 xfer_rvalid,
  input  wire hpsh_pkg::hpsh_word_t xfer_rdata,
  input  wire logic                 xfer_full,
  // Control word written by the host
  output      hpsh_pkg::hpsh_word_t ctrl_word
);
  import hpsh_pkg::*;

  hpsh_dev_state_t state_reg;
  hpsh_dev_state_t state_next;
  logic            strb_q_reg;
  logic            strb_q_next;
  logic            als_q_reg;
  logic            als_q_next;
  hpsh_word_t      hd_q_reg;
  hpsh_word_t      hd_q_next;
  logic            als_held_reg;
  logic            als_held_next;
  hpsh_acc_t       sel_type_reg;
  hpsh_acc_t       sel_type_next;
  logic            sel_rd_reg;
  logic            sel_rd_next;
  logic            sel_order_reg;
  logic            sel_order_next;
  logic            wait_reg;
  logic            wait_next;
  logic            oe_reg;
  logic            oe_next;
  hpsh_word_t      dout_reg;
  hpsh_word_t      dout_next;
  hpsh_word_t      word_reg;
  hpsh_word_t      word_next;
  hpsh_word_t      addr_reg;
  hpsh_word_t      addr_next;
  hpsh_word_t      ctrl_reg;
  hpsh_word_t      ctrl_next;
  logic            fetch_reg;
  logic            fetch_next;
  logic            push_reg;
  logic            push_next;
  hpsh_word_t      wdata_reg;
  hpsh_word_t      wdata_next;

  logic            strobe_n;
  logic            strb_fall;
  logic            strb_rise;
  logic            als_fall;
  logic            hw_mode;
  hpsh_acc_t       cur_type;
  logic            cur_rd;
  logic            cur_order;
  logic            cur_data;
  logic            cur_done;
  hpsh_word_t      cur_src;

  // Halfword mode places the selected half on the low lanes
  function automatic hpsh_word_t rd_half(input hpsh_word_t w, input logic hw,
                                         input logic order);
    rd_half = w;
    if (hw) begin
      rd_half = {16'h0000, (order ? w[31:16] : w[15:0])};
    end
  endfunction

  // First halfword fills the low half, second the high half
  function automatic hpsh_word_t wr_merge(input hpsh_word_t old, input hpsh_word_t nw,
                                          input logic hw, input logic order);
    wr_merge = nw;
    if (hw) begin
      wr_merge = order ? {nw[15:0], old[15:0]} : {old[31:16], nw[15:0]};
    end
  endfunction

  assign strobe_n = link.host_chip_select_n
                  | ~(link.host_data_strobe_one ^ link.host_data_strobe_two); // [RL1]
  assign strb_fall = strb_q_reg & ~strobe_n;
  assign strb_rise = ~strb_q_reg & strobe_n;
  assign als_fall  = als_q_reg & ~link.addr_latch_strobe_n;
  assign hw_mode   = link.halfword_bus_mode;

  // Latched selects win when the latch strobe was used, else live pins
  assign cur_type  = als_held_reg ? sel_type_reg : link.access_type_select; // [RL7] [RL9]
  assign cur_rd    = als_held_reg ? sel_rd_reg : link.read_write_select; // [RL9]
  assign cur_order = hw_mode & (als_held_reg ? sel_order_reg
                                             : link.halfword_order_select); // [RL2]
  assign cur_data  = cur_type[1];
  assign cur_done  = ~hw_mode | cur_order;
  assign cur_src   = (cur_type == `HPSH_ACC_CTRL) ? ctrl_reg
                   : ((cur_type == `HPSH_ACC_ADDR) ? addr_reg : word_reg);

  always_comb begin
    state_next     = state_reg;
    strb_q_next    = strobe_n;
    als_q_next     = link.addr_latch_strobe_n;
    hd_q_next      = link.host_data_bus;
    als_held_next  = als_held_reg;
    sel_type_next  = sel_type_reg;
    sel_rd_next    = sel_rd_reg;
    sel_order_next = sel_order_reg;
    oe_next        = oe_reg;
    dout_next      = dout_reg;
    word_next      = word_reg;
    addr_next      = addr_reg;
    ctrl_next      = ctrl_reg;
    fetch_next     = 1'b0;
    push_next      = 1'b0;
    wdata_next     = wdata_reg;
    if (push_reg && (sel_type_reg == `HPSH_ACC_DATA_INC)) begin
      addr_next = addr_reg + `HPSH_ADDR_STEP;
    end

    if (strb_rise) begin
      als_held_next = 1'b0;
    end
    // Address latch falling while the strobe is idle captures the selects
    if (als_fall && strobe_n) begin // [RL9]
      als_held_next  = 1'b1;
      sel_type_next  = link.access_type_select; // [RL2]
      sel_rd_next    = link.read_write_select;
      sel_order_next = hw_mode & link.halfword_order_select;
    end

    unique case (state_reg)
      DEV_IDLE: begin
        if (strb_fall) begin
          sel_type_next  = cur_type; // [RL9]
          sel_rd_next    = cur_rd;
          sel_order_next = cur_order;
          if (cur_rd) begin
            oe_next = 1'b1; // [RL8]
            if (cur_data && !cur_order) begin
              fetch_next = 1'b1; // [RL4]
              state_next = DEV_FETCH;
            end else begin
              dout_next  = rd_half(cur_src, hw_mode, cur_order);
              state_next = DEV_HOLD;
            end
          end else if (cur_data && cur_done && xfer_full) begin
            state_next = DEV_STALL; // [RL5]
          end else begin
            state_next = DEV_HOLD;
          end
        end
      end
      DEV_FETCH: begin
        if (strb_rise) begin
          oe_next    = 1'b0;
          state_next = DEV_IDLE;
        end else if (xfer_rvalid) begin // [RL4]
          word_next  = xfer_rdata;
          dout_next  = rd_half(xfer_rdata, hw_mode, sel_order_reg);
          state_next = DEV_HOLD;
          if (sel_type_reg == `HPSH_ACC_DATA_INC) begin
            addr_next = addr_reg + `HPSH_ADDR_STEP;
          end
        end
      end
      DEV_STALL: begin
        if (strb_rise) begin
          state_next = DEV_IDLE;
        end else if (!xfer_full) begin // [RL5]
          state_next = DEV_HOLD;
        end
      end
      DEV_HOLD: begin
        if (strb_rise) begin
          oe_next    = 1'b0; // [RL8]
          state_next = DEV_IDLE;
          if (!sel_rd_reg) begin
            // Write data was on the bus in the last cycle of the strobe
            unique case (sel_type_reg)
              `HPSH_ACC_CTRL: begin
                ctrl_next = wr_merge(ctrl_reg, hd_q_reg, hw_mode, sel_order_reg);
              end
              `HPSH_ACC_ADDR: begin
                addr_next = wr_merge(addr_reg, hd_q_reg, hw_mode, sel_order_reg);
              end
              `HPSH_ACC_DATA_INC, `HPSH_ACC_DATA_FIX: begin
                word_next  = wr_merge(word_reg, hd_q_reg, hw_mode, sel_order_reg);
                wdata_next = wr_merge(word_reg, hd_q_reg, hw_mode, sel_order_reg);
                if (!hw_mode || sel_order_reg) begin
                  push_next = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default: begin
        oe_next    = 1'b0;
        state_next = DEV_IDLE;
      end
    endcase

    // Ready only while an access is held; high otherwise
    wait_next = (state_next != DEV_HOLD); // [RL4] [RL5]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= DEV_IDLE;
      strb_q_reg    <= 1'b1;
      als_q_reg     <= 1'b1;
      hd_q_reg      <= `HPSH_RST_WORD;
      als_held_reg  <= 1'b0;
      sel_type_reg  <= `HPSH_ACC_CTRL;
      sel_rd_reg    <= 1'b0;
      sel_order_reg <= 1'b0;
      wait_reg      <= 1'b1;
      oe_reg        <= 1'b0;
      dout_reg      <= `HPSH_RST_WORD;
      word_reg      <= `HPSH_RST_WORD;
      addr_reg      <= `HPSH_RST_WORD;
      ctrl_reg      <= `HPSH_RST_WORD;
      fetch_reg     <= 1'b0;
      push_reg      <= 1'b0;
      wdata_reg     <= `HPSH_RST_WORD;
    end else begin
      state_reg     <= state_next;
      strb_q_reg    <= strb_q_next;
      als_q_reg     <= als_q_next;
      hd_q_reg      <= hd_q_next;
      als_held_reg  <= als_held_next;
      sel_type_reg  <= sel_type_next;
      sel_rd_reg    <= sel_rd_next;
      sel_order_reg <= sel_order_next;
      wait_reg      <= wait_next;
      oe_reg        <= oe_next;
      dout_reg      <= dout_next;
      word_reg      <= word_next;
      addr_reg      <= addr_next;
      ctrl_reg      <= ctrl_next;
      fetch_reg     <= fetch_next;
      push_reg      <= push_next;
      wdata_reg     <= wdata_next;
    end
  end

  assign link.host_wait_indicator = wait_reg;
  assign link.dev_out             = dout_reg;
  assign link.dev_oe              = oe_reg;
  assign xfer_fetch               = fetch_reg;
  assign xfer_push                = push_reg;
  assign xfer_addr                = addr_reg;
  assign xfer_wdata               = wdata_reg;
  assign ctrl_word                = ctrl_reg;
endmodule

// >>> verilog/hpsh_host.sv
`timescale 1ns/1ps
`include "hpsh_regs.svh"
module hpsh_host (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire hpsh_pkg::hpsh_word_t pwdata,
  output      hpsh_pkg::hpsh_word_t prdata,
  output      logic                 pready,
  output      logic                 pslverr,
  // Link to the device
  hpsh_if.host                      link
);
  import hpsh_pkg::*;

  hpsh_host_state_t state_reg;
  hpsh_host_state_t state_next;
  logic [1:0]       ctrl_reg;
  logic [1:0]       ctrl_next;
  hpsh_acc_t        type_reg;
  hpsh_acc_t        type_next;
  logic             rd_reg;
  logic             rd_next;
  logic             order_reg;
  logic             order_next;
  hpsh_word_t       wdata_reg;
  hpsh_word_t       wdata_next;
  hpsh_word_t       rdata_reg;
  hpsh_word_t       rdata_next;
  logic             busy_reg;
  logic             busy_next;
  logic             done_reg;
  logic             done_next;
  logic [2:0]       cnt_reg;
  logic [2:0]       cnt_next;
  logic             strb_reg;
  logic             strb_next;
  logic             als_n_reg;
  logic             als_n_next;
  logic             oe_reg;
  logic             oe_next;
  hpsh_word_t       prdata_reg;
  hpsh_word_t       prdata_next;

  logic             wr_acc;
  logic             mapped;

  assign mapped = (paddr == `HPSH_OFS_CTRL) || (paddr == `HPSH_OFS_CMD)
               || (paddr == `HPSH_OFS_WDATA) || (paddr == `HPSH_OFS_RDATA)
               || (paddr == `HPSH_OFS_STATUS);
  assign wr_acc = psel & penable & pwrite & mapped;

  always_comb begin
    state_next  = state_reg;
    ctrl_next   = ctrl_reg;
    type_next   = type_reg;
    rd_next     = rd_reg;
    order_next  = order_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    busy_next   = busy_reg;
    done_next   = done_reg;
    cnt_next    = cnt_reg;
    strb_next   = strb_reg;
    als_n_next  = als_n_reg;
    oe_next     = oe_reg;
    prdata_next = prdata_reg;

    if (psel && !penable) begin
      unique case (paddr)
        `HPSH_OFS_CTRL:   prdata_next = {30'h00000000, ctrl_reg};
        `HPSH_OFS_CMD:    prdata_next = {28'h0000000, order_reg, rd_reg, type_reg};
        `HPSH_OFS_WDATA:  prdata_next = wdata_reg;
        `HPSH_OFS_RDATA:  prdata_next = rdata_reg;
        `HPSH_OFS_STATUS: prdata_next = {30'h00000000, done_reg, busy_reg};
        default:          prdata_next = 32'h00000000;
      endcase
    end

    if (wr_acc && !busy_reg) begin
      unique case (paddr)
        `HPSH_OFS_CTRL:  ctrl_next  = pwdata[1:0];
        `HPSH_OFS_WDATA: wdata_next = pwdata;
        `HPSH_OFS_CMD: begin
          type_next  = pwdata[`HPSH_CMD_TYPE_LSB +: 2]; // [RL2]
          rd_next    = pwdata[`HPSH_CMD_RD_BIT];
          order_next = pwdata[`HPSH_CMD_ORDER_BIT];
          busy_next  = 1'b1;
          done_next  = 1'b0;
          // One latch pulse per strobe, or none when unused
          als_n_next = ~ctrl_reg[`HPSH_CTRL_ALS_BIT]; // [RL6] [RL7]
          state_next = HST_SETUP;
        end
        default: begin
        end
      endcase
    end

    unique case (state_reg)
      HST_IDLE: begin
      end
      HST_SETUP: begin
        strb_next  = 1'b1;
        oe_next    = ~rd_reg;
        cnt_next   = 3'(`HPSH_STB_LOW_CYC - 1);
        state_next = HST_LOW;
      end
      HST_LOW: begin
        als_n_next = 1'b1;
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else if (!link.host_wait_indicator) begin // [RL3]
          if (rd_reg) begin
            rdata_next = link.host_data_bus;
            if (ctrl_reg[`HPSH_CTRL_HW_BIT]) begin
              rdata_next = {16'h0000, link.host_data_bus[15:0]};
            end
          end
          strb_next  = 1'b0;
          cnt_next   = 3'(`HPSH_STB_HIGH_CYC - 1);
          state_next = HST_GAP;
        end
      end
      HST_GAP: begin
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else begin
          oe_next    = 1'b0;
          busy_next  = 1'b0;
          done_next  = 1'b1;
          state_next = HST_IDLE;
        end
      end
      default: begin
        strb_next  = 1'b0;
        oe_next    = 1'b0;
        busy_next  = 1'b0;
        state_next = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= HST_IDLE;
      ctrl_reg   <= 2'h0;
      type_reg   <= `HPSH_ACC_CTRL;
      rd_reg     <= 1'b0;
      order_reg  <= 1'b0;
      wdata_reg  <= `HPSH_RST_WORD;
      rdata_reg  <= `HPSH_RST_WORD;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      cnt_reg    <= 3'h0;
      strb_reg   <= 1'b0;
      als_n_reg  <= 1'b1;
      oe_reg     <= 1'b0;
      prdata_reg <= `HPSH_RST_WORD;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      type_reg   <= type_next;
      rd_reg     <= rd_next;
      order_reg  <= order_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      busy_reg   <= busy_next;
      done_reg   <= done_next;
      cnt_reg    <= cnt_next;
      strb_reg   <= strb_next;
      als_n_reg  <= als_n_next;
      oe_reg     <= oe_next;
      prdata_reg <= prdata_next;
    end
  end

  // Strobe by pulling select and the first data strobe low together
  assign link.host_chip_select_n    = ~strb_reg; // [RL1]
  assign link.host_data_strobe_one  = ~strb_reg;
  assign link.host_data_strobe_two  = 1'b1;
  assign link.access_type_select    = type_reg;
  assign link.read_write_select     = rd_reg;
  assign link.halfword_order_select = order_reg;
  assign link.addr_latch_strobe_n   = als_n_reg;
  assign link.halfword_bus_mode     = ctrl_reg[`HPSH_CTRL_HW_BIT];
  assign link.host_out              = wdata_reg;
  assign link.host_oe               = oe_reg;
  assign prdata                     = prdata_reg;
  assign pready                     = 1'b1;
  assign pslverr                    = psel & penable & ~mapped;
endmodule

// >>> sim/hpsh_properties.sv
`timescale 1ns/1ps
module hpsh_properties (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Host side pins
  input wire logic                host_chip_select_n,
  input wire logic                host_data_strobe_one,
  input wire logic                host_data_strobe_two,
  input wire hpsh_pkg::hpsh_acc_t access_type_select,
  input wire logic                read_write_select,
  input wire logic                halfword_order_select,
  input wire logic                addr_latch_strobe_n,
  input wire logic                host_oe,
  // Device side pins
  input wire logic                host_wait_indicator,
  input wire logic                dev_oe
);
  import hpsh_pkg::*;
  logic stb_n;
  assign stb_n = host_chip_select_n | ~(host_data_strobe_one ^ host_data_strobe_two);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wait_release_a: assert property ($rose(stb_n) |=> host_wait_indicator)
    else $error("wait indicator not raised after strobe release");
  ready_in_strobe_a: assert property (!host_wait_indicator |-> !stb_n || $past(!stb_n))
    else $error("ready shown outside an active strobe");
  access_answer_a: assert property ($fell(stb_n) |-> ##[1:60] !host_wait_indicator)
    else $error("access never answered");
  host_hold_a: assert property (!stb_n && host_wait_indicator |=> !stb_n)
    else $error("strobe released before ready");
  strobe_width_a: assert property ($fell(stb_n) |-> !stb_n [*4])
    else $error("strobe low too short");
  gap_width_a: assert property ($rose(stb_n) |-> stb_n [*4])
    else $error("strobe high gap too short");
  latch_once_a: assert property (!stb_n |-> !$fell(addr_latch_strobe_n))
    else $error("address latch pulsed inside active strobe");
  select_hold_a: assert property (!stb_n && $past(!stb_n) |->
    $stable({access_type_select, read_write_select, halfword_order_select}))
    else $error("selects changed during strobe");
  drive_start_a: assert property ($rose(dev_oe) |-> read_write_select && !stb_n)
    else $error("bus driven outside a read");
  drive_release_a: assert property ($rose(stb_n) |=> !dev_oe)
    else $error("bus not released after strobe rise");
  no_clash_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the bus");

  cover property ($rose(dev_oe));
  cover property ($fell(addr_latch_strobe_n));
  cover property ((!stb_n && host_wait_indicator) [*8]);
endmodule

// >>> sim/host_port_strobe_handshake_tb.sv
`timescale 1ns/1ps
`include "hpsh_regs.svh"
`define CHK(nm, ex, sn) begin cmp_count++; if ((sn) !== (ex)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end
module host_port_strobe_handshake_tb;
  import hpsh_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic        xfer_fetch, xfer_push, xfer_rvalid, xfer_full;
  logic [11:0] paddr;
  hpsh_word_t  pwdata, prdata, xfer_addr, xfer_wdata, xfer_rdata, ctrl_word, exp_addr, q;
  int          errors, cmp_count, seed, m;
  hpsh_word_t  push_q[$];

  hpsh_if u_hpsh_if ();
  hpsh_host u_hpsh_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_hpsh_if));
  hpsh_device u_hpsh_device (.pclk(pclk), .presetn(presetn), .link(u_hpsh_if),
    .xfer_fetch(xfer_fetch), .xfer_push(xfer_push), .xfer_addr(xfer_addr),
    .xfer_wdata(xfer_wdata), .xfer_rvalid(xfer_rvalid), .xfer_rdata(xfer_rdata),
    .xfer_full(xfer_full), .ctrl_word(ctrl_word));
  hpsh_properties u_hpsh_properties (.pclk(pclk), .presetn(presetn),
    .host_chip_select_n(u_hpsh_if.host_chip_select_n),
    .host_data_strobe_one(u_hpsh_if.host_data_strobe_one),
    .host_data_strobe_two(u_hpsh_if.host_data_strobe_two),
    .access_type_select(u_hpsh_if.access_type_select),
    .read_write_select(u_hpsh_if.read_write_select),
    .halfword_order_select(u_hpsh_if.halfword_order_select),
    .addr_latch_strobe_n(u_hpsh_if.addr_latch_strobe_n), .host_oe(u_hpsh_if.host_oe),
    .host_wait_indicator(u_hpsh_if.host_wait_indicator), .dev_oe(u_hpsh_if.dev_oe));

  function automatic hpsh_word_t fetch_word(hpsh_word_t a);
    return a ^ 32'h5A3C96E1;
  endfunction

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // Transfer engine: answers each fetch after a random delay
  initial begin
    hpsh_word_t fa;
    xfer_rvalid = 1'h0;
    xfer_rdata = 32'h00000000;
    forever begin
      @(posedge pclk);
      if (xfer_fetch === 1'h1) begin
        fa = xfer_addr;
        repeat (1 + ($unsigned($random(seed)) % 6)) @(posedge pclk);
        xfer_rvalid <= 1'h1;
        xfer_rdata <= fetch_word(fa);
        @(posedge pclk);
        xfer_rvalid <= 1'h0;
        xfer_rdata <= ~fetch_word(fa);
      end
    end
  end

  always @(posedge pclk) begin
    if (xfer_push === 1'h1) begin
      push_q.push_back(xfer_addr);
      push_q.push_back(xfer_wdata);
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input hpsh_word_t d,
                     output hpsh_word_t rq, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rq = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic hop(input hpsh_acc_t t, input logic rd, input logic od, input hpsh_word_t d,
                     output hpsh_word_t rq);
    int n;
    apb(1'h1, `HPSH_OFS_WDATA, d, rq, err_q);
    apb(1'h1, `HPSH_OFS_CMD, {28'h0000000, od, rd, t}, rq, err_q);
    n = 0;
    do begin
      apb(1'h0, `HPSH_OFS_STATUS, 32'h00000000, rq, err_q);
      n++;
    end while (rq[`HPSH_STAT_DONE_BIT] !== 1'h1 && n < 100);
    `CHK("status done", 1'h1, rq[`HPSH_STAT_DONE_BIT])
    apb(1'h0, `HPSH_OFS_RDATA, 32'h00000000, rq, err_q);
  endtask

  // One word: two halfword accesses on the low lanes in halfword mode
  task automatic wop(input hpsh_acc_t t, input logic rd, input logic hw, input hpsh_word_t d,
                     output hpsh_word_t rq);
    hpsh_word_t lo;
    if (!hw) hop(t, rd, 1'h0, d, rq);
    else begin
      hop(t, rd, 1'h0, {16'h0000, d[15:0]}, lo);
      hop(t, rd, 1'h1, {16'h0000, d[31:16]}, rq);
      rq = {rq[15:0], lo[15:0]};
    end
  endtask

  task automatic chk_push(input hpsh_word_t a, input hpsh_word_t d);
    `CHK("push count", 2, push_q.size())
    if (push_q.size() == 2) begin
      `CHK("push addr", a, push_q.pop_front())
      `CHK("push data", d, push_q.pop_front())
    end
    push_q.delete();
  endtask

  task automatic run_mode(input logic hw, input logic als);
    hpsh_word_t d;
    logic [1:0] op;
    hpsh_acc_t  t;
    apb(1'h1, `HPSH_OFS_CTRL, {30'h00000000, als, hw}, q, err_q);
    exp_addr = $random(seed) & 32'h0000FFFC;
    wop(`HPSH_ACC_ADDR, 1'h0, hw, exp_addr, q);
    `CHK("addr reg", exp_addr, xfer_addr)
    wop(`HPSH_ACC_ADDR, 1'h1, hw, 32'h00000000, q);
    `CHK("addr read", exp_addr, q)
    if (!hw) begin
      d = $random(seed);
      wop(`HPSH_ACC_CTRL, 1'h0, 1'h0, d, q);
      `CHK("ctrl word", d, ctrl_word)
      wop(`HPSH_ACC_CTRL, 1'h1, 1'h0, 32'h00000000, q);
      `CHK("ctrl read", d, q)
    end
    if (!hw && !als) begin
      xfer_full <= 1'h1;
      fork
        begin
          repeat (30) @(posedge pclk);
          `CHK("stall wait", 1'h1, u_hpsh_if.host_wait_indicator)
          `CHK("stall push", 0, push_q.size())
          xfer_full <= 1'h0;
        end
      join_none
      d = $random(seed);
      wop(`HPSH_ACC_DATA_FIX, 1'h0, 1'h0, d, q);
      chk_push(exp_addr, d);
    end
    repeat (8) begin
      d = $random(seed);
      op = 2'($random(seed));
      t = op[0] ? `HPSH_ACC_DATA_FIX : `HPSH_ACC_DATA_INC;
      wop(t, op[1], hw, d, q);
      if (op[1]) `CHK("read word", fetch_word(exp_addr), q)
      else chk_push(exp_addr, d);
      if (t == `HPSH_ACC_DATA_INC) exp_addr = exp_addr + `HPSH_ADDR_STEP;
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    end_of_test;
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    xfer_full = 1'h0;
    errors = 0;
    cmp_count = 0;
    seed = 32'h96CF;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h020, 32'h00000000, q, err_q);
    `CHK("unmapped err", 1'h1, err_q)
    `CHK("unmapped data", 32'h00000000, q)
    for (m = 0; m < 4; m++) run_mode(m[1], m[0]);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK("reset ctrl", 32'h00000000, ctrl_word)
    `CHK("reset wait", 1'h1, u_hpsh_if.host_wait_indicator)
    `CHK("reset drive", 1'h0, u_hpsh_if.dev_oe)
    presetn <= 1'h1;
    run_mode(1'h1, 1'h1);
    end_of_test;
  end
endmodule
